//--- ouhp_host_port.sv
// host bus port, address decode and pin roles of the octal uart
// ****************************************
// What this block does
// - low four address bits pick one of sixteen channel registers
// - address bits four to six pick the channel, zero to seven
// - top address bit set targets global registers instead of channel
// - strobe-pair style: read strobe fall starts read, byte driven out
// - strobe-pair style: write starts on fall, data latched on trailing edge
// - strobe-pair style: low chip select enables accesses
// - single-strobe style: write strobe pin is direction, high read, low write
// - single-strobe style: chip select pin is the one strobe for both
// - interrupt is active-low open drain, only pulls low
// - all eight channel interrupts merge onto the one output
// - receive input idles high in normal mode
// - infrared receive pulse optionally inverted by feature control bit four
// - serial out carries normal or infrared transmit data
// - request-to-send is flow control, direction control or general output
// - terminal-ready is flow control, direction control or general output
// - clear-to-send and set-ready feed flow control or read as inputs
// ****************************************
`timescale 1ns/100ps
module ouhp_host_port
    import ouhp_pkg::*;
(
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    input  wire logic                                busStyleSel,
    input  wire logic [ADDR_W-1:0]                   hostAddrLines,
    input  wire logic [DATA_W-1:0]                   hostDataIn,
    output logic      [DATA_W-1:0]                   hostDataOut,
    output logic                                     hostDataOe,
    input  wire logic                                readStrobeN,
    input  wire logic                                writeStrobeN,
    input  wire logic                                chipSelN,
    input  wire logic                                irqLineIn,
    output logic                                     irqLineOut,
    output logic                                     irqLineOe,
    output logic                                     irqLineSeenLow,
    output logic                                     regRdStb,
    output logic                                     regWrStb,
    output ouhp_target_t                             regTarget,
    output logic      [DATA_W-1:0]                   regWrData,
    input  wire logic [DATA_W-1:0]                   regRdData,
    input  wire logic [NUM_CHAN-1:0]                 chanIrq,
    input  wire ouhp_chan_cfg_t  [NUM_CHAN-1:0]      chanCfg,
    input  wire ouhp_chan_core_t [NUM_CHAN-1:0]      chanCore,
    output ouhp_chan_stat_t      [NUM_CHAN-1:0]      chanStat,
    input  wire logic [NUM_CHAN-1:0]                 serialIn,
    input  wire logic [NUM_CHAN-1:0]                 clearSendN,
    input  wire logic [NUM_CHAN-1:0]                 setReadyN,
    input  wire logic [NUM_CHAN-1:0]                 carrierDetectN,
    output logic      [NUM_CHAN-1:0]                 serialOut,
    output logic      [NUM_CHAN-1:0]                 requestSendN,
    output logic      [NUM_CHAN-1:0]                 terminalReadyN
);

    // ****************************************
    // types and helpers
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_READ  = 2'b10,
        ST_WRITE = 2'b11
    } ouhp_state_t;

    localparam int BUS_W  = ADDR_W + DATA_W + 4;
    localparam logic [BUS_W-1:0] BUS_RST = {ADDR_RST, DATA_RST, 4'hf};

    function automatic ouhp_target_t decodeAddr(input logic [ADDR_W-1:0] a);
        ouhp_target_t t;
        t.idx       = a[IDX_LSB +: IDX_W];
        t.chan      = a[CHAN_LSB +: CHAN_W];
        t.globalSel = a[GLOBAL_BIT];
        return t;
    endfunction : decodeAddr

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [BUS_W-1:0]        busSync;
    logic [ADDR_W-1:0]       addrS;
    logic [DATA_W-1:0]       dataS;
    logic                    rdNS;
    logic                    wrNS;
    logic                    csNS;
    logic                    irqS;
    logic                    styleS;
    logic [4*NUM_CHAN-1:0]   serSync;

    ouhp_pin_sync #(
        .W       (BUS_W),
        .RST_VAL (BUS_RST)
    ) u_bus_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   ({hostAddrLines, hostDataIn, readStrobeN, writeStrobeN,
                   chipSelN, irqLineIn}),
        .pinOut  (busSync)
    );

    ouhp_pin_sync #(
        .W       (4*NUM_CHAN),
        .RST_VAL ({(4*NUM_CHAN){PIN_IDLE}})
    ) u_ser_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   ({serialIn, clearSendN, setReadyN, carrierDetectN}),
        .pinOut  (serSync)
    );

    // bus style strap crosses like any other pin
    ouhp_pin_sync #(
        .W       (1),
        .RST_VAL (PIN_IDLE)
    ) u_style_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (busStyleSel),
        .pinOut  (styleS)
    );

    assign {addrS, dataS, rdNS, wrNS, csNS, irqS} = busSync;

    // ****************************************
    // bus style decode
    // ****************************************
    logic rdActive;
    logic wrActive;
    logic rdActQ;
    logic wrActQ;
    logic rdStart;
    logic wrStart;
    logic wrEnd;
    logic rdEnd;

    // strobe pair: chip select gates separate strobes
    // single strobe: chip select is the strobe, write pin is direction
    assign rdActive = styleS ? (!csNS && !rdNS)
                             : (!csNS && wrNS);
    assign wrActive = styleS ? (!csNS && !wrNS)
                             : (!csNS && !wrNS);
    assign rdStart  = rdActive && !rdActQ;
    assign wrStart  = wrActive && !wrActQ;
    assign rdEnd    = !rdActive && rdActQ;
    assign wrEnd    = !wrActive && wrActQ;

    // ****************************************
    // access state machine
    // ****************************************
    ouhp_state_t         stateQ;
    ouhp_state_t         stateD;
    logic [ADDR_W-1:0]   addrQ;
    logic [DATA_W-1:0]   wrHoldQ;
    logic [DATA_W-1:0]   rdDataD;
    logic                oeD;
    logic                rdStbD;
    logic                wrStbD;

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            ST_IDLE: begin
                if (rdStart) begin
                    stateD = ST_FETCH;
                end else if (wrStart) begin
                    stateD = ST_WRITE;
                end
            end
            ST_FETCH: begin
                stateD = rdActive ? ST_READ : ST_IDLE;
            end
            ST_READ: begin
                if (!rdActive) begin
                    stateD = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!wrActive) begin
                    stateD = ST_IDLE;
                end
            end
            default: begin
                stateD = ST_IDLE;
            end
        endcase
    end

    assign rdStbD  = (stateQ == ST_IDLE) && rdStart;
    assign wrStbD  = (stateQ == ST_WRITE) && !wrActive;
    assign oeD     = (stateD == ST_READ);
    assign rdDataD = (stateQ == ST_FETCH) ? regRdData : hostDataOut;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateQ <= ST_IDLE;
            rdActQ <= 1'h0;
            wrActQ <= 1'h0;
        end else begin
            stateQ <= stateD;
            rdActQ <= rdActive;
            wrActQ <= wrActive;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addrQ   <= ADDR_RST;
            wrHoldQ <= DATA_RST;
        end else begin
            if (stateQ == ST_IDLE && (rdStart || wrStart)) begin
                addrQ <= addrS;
            end
            if (wrActive) begin
                wrHoldQ <= dataS;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdStb    <= 1'h0;
            regWrStb    <= 1'h0;
            regTarget   <= '0;
            regWrData   <= DATA_RST;
            hostDataOut <= DATA_RST;
            hostDataOe  <= 1'h0;
        end else begin
            regRdStb    <= rdStbD;
            regWrStb    <= wrStbD;
            regTarget   <= decodeAddr(rdStbD ? addrS : addrQ);
            regWrData   <= wrHoldQ;
            hostDataOut <= rdDataD;
            hostDataOe  <= oeD;
        end
    end

    // ****************************************
    // shared interrupt line
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqLineOut     <= IRQ_LEVEL;
            irqLineOe      <= 1'h0;
            irqLineSeenLow <= 1'h0;
        end else begin
            irqLineOut     <= IRQ_LEVEL;
            irqLineOe      <= |chanIrq;
            irqLineSeenLow <= !irqS;
        end
    end

    // ****************************************
    // channel pins
    // ****************************************
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        ouhp_chan_pins u_chan (
            .clk            (clk),
            .sys_rst        (sys_rst),
            .cfg            (chanCfg[c]),
            .core           (chanCore[c]),
            .serialIn       (serSync[3*NUM_CHAN + c]),
            .clearSendN     (serSync[2*NUM_CHAN + c]),
            .setReadyN      (serSync[NUM_CHAN + c]),
            .carrierDetectN (serSync[c]),
            .serialOut      (serialOut[c]),
            .requestSendN   (requestSendN[c]),
            .terminalReadyN (terminalReadyN[c]),
            .stat           (chanStat[c])
        );
    end

    // ****************************************
    // assertions
    // ****************************************
    a_idx_decode: assert property (@(posedge clk) disable iff (sys_rst)
        rdStbD |=> regTarget.idx == $past(addrS[IDX_LSB +: IDX_W]))
        else $error("register index not taken from low address bits");

    a_chan_decode: assert property (@(posedge clk) disable iff (sys_rst)
        regWrStb |-> regTarget.chan == addrQ[CHAN_LSB +: CHAN_W])
        else $error("channel not taken from address bits four to six");

    a_global_sel: assert property (@(posedge clk) disable iff (sys_rst)
        rdStbD |=> regTarget.globalSel == $past(addrS[GLOBAL_BIT]))
        else $error("global select not taken from top address bit");

    a_read_start: assert property (@(posedge clk) disable iff (sys_rst)
        styleS && stateQ == ST_IDLE && !csNS && !rdNS && !rdActQ
        |=> regRdStb ##1 (hostDataOut == $past(regRdData) || !hostDataOe))
        else $error("read strobe fall did not fetch and present the byte");

    a_write_trail: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == ST_WRITE && !wrActive |=> regWrStb && regWrData == $past(wrHoldQ))
        else $error("write not committed on strobe trailing edge");

    a_cs_gate: assert property (@(posedge clk) disable iff (sys_rst)
        csNS |-> !rdActive && !wrActive)
        else $error("access taken with chip select high");

    a_dir_line: assert property (@(posedge clk) disable iff (sys_rst)
        !styleS && rdStart |-> wrNS)
        else $error("single-strobe read with direction low");

    a_one_strobe: assert property (@(posedge clk) disable iff (sys_rst)
        !styleS && !csNS && !wrNS && !wrActQ |=> stateQ != ST_IDLE || stateD != ST_IDLE
        || $past(stateQ) != ST_IDLE)
        else $error("single-strobe write not started");

    a_irq_drain: assert property (@(posedge clk) disable iff (sys_rst)
        irqLineOe |-> irqLineOut == IRQ_LEVEL)
        else $error("interrupt pin drives high");

    a_irq_merge: assert property (@(posedge clk) disable iff (sys_rst)
        |chanIrq |=> irqLineOe)
        else $error("channel interrupt not merged onto line");

    a_oe_read: assert property (@(posedge clk) disable iff (sys_rst)
        hostDataOe |-> stateQ == ST_READ && $past(rdActive))
        else $error("data bus driven outside a read");

    a_oe_release: assert property (@(posedge clk) disable iff (sys_rst)
        rdEnd |=> !hostDataOe)
        else $error("data bus not released after read");

    a_oe_data: assert property (@(posedge clk) disable iff (sys_rst)
        hostDataOe && $past(stateQ) == ST_FETCH |-> hostDataOut == $past(regRdData))
        else $error("fetched byte not presented on the data bus");

    a_wr_single: assert property (@(posedge clk) disable iff (sys_rst)
        !styleS && stateQ == ST_WRITE && csNS |=> regWrStb)
        else $error("single-strobe write not committed on strobe release");

    c_read: cover property (@(posedge clk) disable iff (sys_rst)
        regRdStb ##[1:4] hostDataOe);
    c_write: cover property (@(posedge clk) disable iff (sys_rst)
        wrEnd ##1 regWrStb);
    c_single: cover property (@(posedge clk) disable iff (sys_rst)
        !styleS && rdStart);
    c_single_wr: cover property (@(posedge clk) disable iff (sys_rst)
        !styleS && wrStart);
    c_irq: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(irqLineOe));

endmodule : ouhp_host_port

//--- ouhp_pkg.sv
// constants and types of the octal uart host port
package ouhp_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_CHAN   = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int IDX_LSB    = 0;
    localparam int IDX_W      = 4;
    localparam int CHAN_LSB   = 4;
    localparam int CHAN_W     = 3;
    localparam int GLOBAL_BIT = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ADDR_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic       PIN_IDLE  = 1'h1;
    localparam logic       IRQ_LEVEL = 1'h0;

    // decoded register target
    typedef struct packed {
        logic              globalSel;
        logic [CHAN_W-1:0] chan;
        logic [IDX_W-1:0]  idx;
    } ouhp_target_t;

    // per-channel configuration from the register core
    typedef struct packed {
        logic irMode;
        logic irInvert;
        logic flowAuto;
        logic flowUseDtr;
        logic halfDuplex;
        logic rtsGpo;
        logic dtrGpo;
    } ouhp_chan_cfg_t;

    // per-channel live signals from the uart core
    typedef struct packed {
        logic txData;
        logic irTxData;
        logic rxRoom;
        logic txBusy;
    } ouhp_chan_core_t;

    // per-channel pin state back to the core
    typedef struct packed {
        logic rxData;
        logic irRxPulse;
        logic txAllowed;
        logic ctsActive;
        logic dsrActive;
        logic cdActive;
    } ouhp_chan_stat_t;

endpackage : ouhp_pkg

//--- ouhp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ouhp_pin_sync
    import ouhp_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);

    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    logic [W-1:0] outD;

    // a bit moves only when stages two and three agree
    assign outD = (s2Q & s3Q) | (pinOut & (s2Q ^ s3Q));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1Q    <= RST_VAL;
            s2Q    <= RST_VAL;
            s3Q    <= RST_VAL;
            pinOut <= RST_VAL;
        end else begin
            s1Q    <= pinIn;
            s2Q    <= s1Q;
            s3Q    <= s2Q;
            pinOut <= outD;
        end
    end

endmodule : ouhp_pin_sync

//--- ouhp_chan_pins.sv
// pin function selection of one serial channel
`timescale 1ns/100ps
module ouhp_chan_pins
    import ouhp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire ouhp_chan_cfg_t  cfg,
    input  wire ouhp_chan_core_t core,
    input  wire logic            serialIn,
    input  wire logic            clearSendN,
    input  wire logic            setReadyN,
    input  wire logic            carrierDetectN,
    output logic                 serialOut,
    output logic                 requestSendN,
    output logic                 terminalReadyN,
    output ouhp_chan_stat_t      stat
);

    logic            txD;
    logic            dirLevelN;
    logic            flowLevelN;
    logic            rtsD;
    logic            dtrD;
    ouhp_chan_stat_t statD;

    assign txD        = cfg.irMode ? core.irTxData : core.txData;
    assign dirLevelN  = ~core.txBusy;
    assign flowLevelN = ~core.rxRoom;
    assign rtsD = cfg.halfDuplex ? dirLevelN :
                  (cfg.flowAuto && !cfg.flowUseDtr) ? flowLevelN : ~cfg.rtsGpo;
    assign dtrD = cfg.halfDuplex ? dirLevelN :
                  (cfg.flowAuto && cfg.flowUseDtr) ? flowLevelN : ~cfg.dtrGpo;
    assign statD.rxData    = cfg.irMode ? PIN_IDLE : serialIn;
    assign statD.irRxPulse = cfg.irMode & (serialIn ^ cfg.irInvert);
    assign statD.txAllowed = !cfg.flowAuto ||
                             (cfg.flowUseDtr ? !setReadyN : !clearSendN);
    assign statD.ctsActive = ~clearSendN;
    assign statD.dsrActive = ~setReadyN;
    assign statD.cdActive  = ~carrierDetectN;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serialOut      <= PIN_IDLE;
            requestSendN   <= PIN_IDLE;
            terminalReadyN <= PIN_IDLE;
            stat           <= '0;
        end else begin
            serialOut      <= txD;
            requestSendN   <= rtsD;
            terminalReadyN <= dtrD;
            stat           <= statD;
        end
    end

    a_ir_invert: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.irMode |=> stat.irRxPulse == ($past(serialIn) ^ $past(cfg.irInvert)))
        else $error("ir receive pulse not inverted as configured");
    a_rx_normal: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.irMode |=> stat.rxData == $past(serialIn))
        else $error("normal receive data does not follow pin");
    a_cts_flow: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.flowAuto && !cfg.flowUseDtr && clearSendN |=> !stat.txAllowed)
        else $error("transmit allowed while clear-to-send inactive");

endmodule : ouhp_chan_pins

//--- ouhp_host_model.sv
// host processor model driving the parallel bus pins
`timescale 1ns/100ps
module ouhp_host_model
    import ouhp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              style,
    input  wire logic [DATA_W-1:0] devData,
    input  wire logic              devOe,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] dataWire,
    output logic                   readStrobeN,
    output logic                   writeStrobeN,
    output logic                   chipSelN
);
    // ****************************************
    // data wire and bus cycles
    // ****************************************
    logic [DATA_W-1:0] drv;
    logic              drvOe;
    logic [DATA_W-1:0] last_q;

    // released wire keeps changing, never holds its last value
    assign dataWire = devOe ? devData : (drvOe ? drv : ~last_q);

    always_ff @(posedge clk) begin
        last_q <= dataWire;
    end

    initial begin
        addr         = '0;
        drv          = '0;
        drvOe        = 1'h0;
        readStrobeN  = 1'h1;
        writeStrobeN = 1'h1;
        chipSelN     = 1'h1;
    end

    // one access; selN high models an unselected cycle
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          input logic selN, output logic [7:0] q);
        @(negedge clk);
        addr  = a;
        drv   = d;
        drvOe = wr;
        if (!style) begin
            writeStrobeN = ~wr;
        end
        @(negedge clk);
        chipSelN = selN;
        if (style) begin
            readStrobeN  = wr;
            writeStrobeN = ~wr;
        end
        repeat (8) @(negedge clk);
        q            = dataWire;
        chipSelN     = 1'h1;
        readStrobeN  = 1'h1;
        writeStrobeN = style ? 1'h1 : ~wr;
        repeat (7) @(negedge clk);
        drvOe        = 1'h0;
        writeStrobeN = 1'h1;
        repeat (2) @(negedge clk);
    endtask : access
endmodule : ouhp_host_model

//--- tb_top.sv
// self-checking bench of the octal uart host port
`timescale 1ns/100ps
module tb_top
    import ouhp_pkg::*;
;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk, sys_rst, busStyleSel, otherPull, irqLineIn, irqLineOut, irqLineOe;
    logic irqLineSeenLow, regRdStb, regWrStb, hostDataOe, rdN, wrN, csN;
    logic [7:0] hostAddr, dataWire, hostDataOut, regWrData, regRdData, chanIrq;
    logic [7:0] serialIn, clearSendN, setReadyN, carrierDetectN;
    logic [7:0] serialOut, requestSendN, terminalReadyN, rdTgt, wrTgt, wrDat, a, q;
    ouhp_target_t                   regTarget;
    ouhp_chan_cfg_t  [NUM_CHAN-1:0] chanCfg;
    ouhp_chan_core_t [NUM_CHAN-1:0] chanCore;
    ouhp_chan_stat_t [NUM_CHAN-1:0] chanStat;
    logic [63:0] r;
    logic [31:0] seed;
    int          n_errors, tests_run, nRd, nWr;
    int          rdCnt = 0;
    int          wrCnt = 0;

    assign irqLineIn = ~((irqLineOe & ~irqLineOut) | otherPull);
    assign regRdData = regTarget ^ 8'ha5;

    ouhp_host_port ouhp_host_port_inst (.clk(clk), .sys_rst(sys_rst),
        .busStyleSel(busStyleSel), .hostAddrLines(hostAddr), .hostDataIn(dataWire),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .readStrobeN(rdN),
        .writeStrobeN(wrN), .chipSelN(csN), .irqLineIn(irqLineIn),
        .irqLineOut(irqLineOut), .irqLineOe(irqLineOe), .irqLineSeenLow(irqLineSeenLow),
        .regRdStb(regRdStb), .regWrStb(regWrStb), .regTarget(regTarget),
        .regWrData(regWrData), .regRdData(regRdData), .chanIrq(chanIrq),
        .chanCfg(chanCfg), .chanCore(chanCore), .chanStat(chanStat),
        .serialIn(serialIn), .clearSendN(clearSendN), .setReadyN(setReadyN),
        .carrierDetectN(carrierDetectN), .serialOut(serialOut),
        .requestSendN(requestSendN), .terminalReadyN(terminalReadyN));

    ouhp_host_model ouhp_host_model_inst (.clk(clk), .style(busStyleSel),
        .devData(hostDataOut), .devOe(hostDataOe), .addr(hostAddr), .dataWire(dataWire),
        .readStrobeN(rdN), .writeStrobeN(wrN), .chipSelN(csN));

    // ****************************************
    // helpers
    // ****************************************
    always @(posedge clk) begin
        if (regRdStb === 1'h1) begin
            rdCnt <= rdCnt + 1;
            rdTgt <= regTarget;
        end
        if (regWrStb === 1'h1) begin
            wrCnt <= wrCnt + 1;
            wrTgt <= regTarget;
            wrDat <= regWrData;
        end
    end

    function automatic logic [31:0] rnd();
        seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h0);
        return seed;
    endfunction : rnd

    function automatic logic [7:0] tgtExp(input logic [7:0] x);
        return {x[GLOBAL_BIT], x[CHAN_LSB +: CHAN_W], x[IDX_LSB +: IDX_W]};
    endfunction : tgtExp

    function automatic logic [7:0] pinExp(input ouhp_chan_cfg_t c, input ouhp_chan_core_t k);
        logic rts, dtr;
        rts = c.halfDuplex ? ~k.txBusy : ((c.flowAuto & ~c.flowUseDtr) ? ~k.rxRoom : ~c.rtsGpo);
        dtr = c.halfDuplex ? ~k.txBusy : ((c.flowAuto & c.flowUseDtr) ? ~k.rxRoom : ~c.dtrGpo);
        return {5'h0, c.irMode ? k.irTxData : k.txData, rts, dtr};
    endfunction : pinExp

    function automatic logic [7:0] statExp(input ouhp_chan_cfg_t c, input logic [3:0] p);
        logic txOk;
        txOk = ~c.flowAuto | (c.flowUseDtr ? ~p[2] : ~p[1]);
        return {2'h0, c.irMode | p[0], c.irMode & (p[0] ^ c.irInvert), txOk, ~p[1], ~p[2], ~p[3]};
    endfunction : statExp

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // clock, watchdog and sequence
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        {sys_rst, busStyleSel, otherPull, chanIrq, chanCfg, chanCore} = '0;
        {serialIn, clearSendN, setReadyN, carrierDetectN} = '1;
        {n_errors, tests_run, nRd, nWr} = '0;
        seed = 32'h53;
        sys_rst = 1'h1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("reset pins", {hostDataOe, irqLineOe, serialOut[5:0]}, 8'h3f);
        sys_rst = 1'h0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            r = {rnd(), rnd()};
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h80 : r[7:0];
            busStyleSel = i[0];
            ouhp_host_model_inst.access(1'h1, a, r[15:8], 1'h0, q);
            nWr++;
            chk("write count", 8'(wrCnt), 8'(nWr));
            chk("write target", wrTgt, tgtExp(a));
            chk("write data", wrDat, r[15:8]);
            ouhp_host_model_inst.access(1'h0, a, 8'h00, 1'h0, q);
            nRd++;
            chk("read count", 8'(rdCnt), 8'(nRd));
            chk("read target", rdTgt, tgtExp(a));
            chk("read data", q, tgtExp(a) ^ 8'ha5);
            chk("data released", 8'(hostDataOe), 8'h00);
            ouhp_host_model_inst.access(i[1], a, r[23:16], 1'h1, q);
            chk("unselected", 8'(rdCnt + wrCnt), 8'(nRd + nWr));
        end
        for (int i = 0; i < 24; i++) begin
            @(negedge clk);
            r = {rnd(), rnd()};
            chanCfg = (i == 0) ? '0 : (i == 1) ? '1 : r[55:0];
            chanCore = rnd();
            {serialIn, clearSendN, setReadyN, carrierDetectN} = rnd();
            repeat (7) @(negedge clk);
            for (int c = 0; c < NUM_CHAN; c++) begin
                chk("chan pins", {5'h0, serialOut[c], requestSendN[c], terminalReadyN[c]},
                    pinExp(chanCfg[c], chanCore[c]));
                chk("chan stat", {2'h0, chanStat[c].rxData, chanStat[c].irRxPulse,
                    chanStat[c].txAllowed, chanStat[c].ctsActive, chanStat[c].dsrActive,
                    chanStat[c].cdActive}, statExp(chanCfg[c], {carrierDetectN[c],
                    setReadyN[c], clearSendN[c], serialIn[c]}));
            end
        end
        for (int c = 0; c <= NUM_CHAN; c++) begin
            @(negedge clk);
            chanIrq = (c < NUM_CHAN) ? (8'h01 << c) : 8'h00;
            repeat (2) @(negedge clk);
            chk("irq drive", 8'({irqLineOe, irqLineOut}),
                (c < NUM_CHAN) ? 8'h02 : 8'h00);
        end
        otherPull = 1'h1;
        repeat (6) @(negedge clk);
        chk("irq seen low", 8'({irqLineOe, irqLineSeenLow}), 8'h01);
        otherPull = 1'h0;
        repeat (6) @(negedge clk);
        chk("irq released", 8'(irqLineSeenLow), 8'h00);
        wrap_up();
    end
endmodule : tb_top
